// >>> pcsc_pkg.sv
// Purpose: constants for the PLL clock select control block
// Assumes: APB slave, 32-bit data, one SYS_CLK domain at 200 MHz
// Notes: register offsets are byte addresses
package pcsc_pkg;
  localparam logic [11:0] ADDR_PLL_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_PLL_BANDWIDTH_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_PLL_PROGRAMMING = 12'h008;
  // pll_control fields
  localparam int BIT_LOCK_IRQ_ENABLE = 7;
  localparam int BIT_LOCK_CHANGE_FLAG = 6;
  localparam int BIT_PLL_ON = 5;
  localparam int BIT_BASE_SELECT = 4;
  localparam logic [3:0] CTRL_LOW_ONES = 4'hF;
  // pll_bandwidth_control fields
  localparam int BIT_AUTO_MODE = 7;
  localparam int BIT_LOCK = 6;
  localparam int BIT_TRACK = 5;
  localparam int BIT_CRYSTAL_LOSS = 4;
  // pll_programming fields and reset
  localparam logic [3:0] MULTIPLIER_RESET = 4'h6;
  localparam logic [3:0] RANGE_RESET = 4'h6;
  // Input sample positions
  localparam int SYN_XTAL = 0;
  localparam int SYN_VCO = 1;
  localparam int SYN_LOCK = 2;
  localparam int SYN_TRACK = 3;
  localparam int SYN_W = 4;
  // Switchover edge counts
  localparam logic [1:0] SWITCH_EDGES = 2'h3;
endpackage

// >>> pcsc_src_model.sv
// Purpose: source clocks and lock levels seen by the block
// Assumes: half periods are multiples of 10 ns
// Notes: a stopped source rests low, like a halted oscillator
`timescale 1ns/10ps
module pcsc_src_model #(
  parameter int XTAL_HALF = 30,
  parameter int VCO_HALF = 20
) (
  input wire logic xtal_run,
  input wire logic vco_run,
  input wire logic lock_set,
  input wire logic track_set,
  output logic xtal_clk,
  output logic vco_clk,
  output logic lock_lvl,
  output logic track_lvl
);
  initial begin
    xtal_clk = 1'b0;
    forever #XTAL_HALF xtal_clk = xtal_run & ~xtal_clk;
  end
  initial begin
    vco_clk = 1'b0;
    forever #VCO_HALF vco_clk = vco_run & ~vco_clk;
  end
  assign lock_lvl = lock_set;
  assign track_lvl = track_set;
endmodule

// >>> pcsc_top.sv
// Purpose: control, status and base clock selection of a clock generator
// Assumes: crystal, VCO, lock and track inputs sampled on SYS_CLK
// Notes: source clocks must be well below SYS_CLK / 4 to be followed
`timescale 1ns/10ps
module pcsc_top (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic XTAL_CLOCK_IN,
  input wire logic VCO_CLOCK_IN,
  input wire logic LOCK_IN,
  input wire logic TRACK_IN,
  input wire logic OSC_ENABLE_IN,
  input wire logic STOP_IN,
  output logic CRYSTAL_CLOCK,
  output logic BASE_CLOCK,
  output logic CLOCKGEN_IRQ,
  output logic PLL_ENABLE,
  output logic FILTER_TRACK
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [pcsc_pkg::SYN_W-1:0] syn1_q, syn2_q, syn3_q;
  logic [pcsc_pkg::SYN_W-1:0] syn1_d, syn2_d, syn3_d;
  logic irq_en_q, irq_en_d;
  logic flag_q, flag_d;
  logic pll_on_q, pll_on_d;
  logic bcs_q, bcs_d;
  logic auto_q, auto_d;
  logic acq_man_q, acq_man_d;
  logic xld_q, xld_d;
  logic xld_busy_q, xld_busy_d;
  logic [5:0] xld_cnt_q, xld_cnt_d;
  logic [3:0] mul_q, mul_d;
  logic [3:0] range_q, range_d;
  logic sel_q, sel_d;
  logic [1:0] cnt_x_q, cnt_x_d;
  logic [1:0] cnt_v_q, cnt_v_d;
  logic base_q, base_d;
  logic xclk_q, xclk_d;
  logic irq_q, irq_d;
  logic pll_en_q, pll_en_d;
  logic track_q, track_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic rd_ctrl_q, rd_ctrl_d;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic setup, done, wr, hit_ctrl, hit_bw, hit_prog;
  logic xe, ve, lock_s, toggle, range_ok;
  logic [3:0] n_eff;
  logic [5:0] xld_limit;
  logic [7:0] ctrl_rd, bw_rd;

  always_comb begin
    syn1_d = {TRACK_IN, LOCK_IN, VCO_CLOCK_IN, XTAL_CLOCK_IN};
    syn2_d = syn1_q;
    syn3_d = syn2_q;
    irq_en_d = irq_en_q;
    flag_d = flag_q;
    pll_on_d = pll_on_q;
    bcs_d = bcs_q;
    auto_d = auto_q;
    acq_man_d = acq_man_q;
    xld_d = xld_q;
    xld_busy_d = xld_busy_q;
    xld_cnt_d = xld_cnt_q;
    mul_d = mul_q;
    range_d = range_q;
    sel_d = sel_q;
    cnt_x_d = cnt_x_q;
    cnt_v_d = cnt_v_q;
    base_d = base_q;
    rd_ctrl_d = rd_ctrl_q;

    setup = PSEL & ~PENABLE;
    done = PSEL & PENABLE & pready_q;
    wr = done & PWRITE;
    hit_ctrl = PADDR == pcsc_pkg::ADDR_PLL_CONTROL;
    hit_bw = PADDR == pcsc_pkg::ADDR_PLL_BANDWIDTH_CONTROL;
    hit_prog = PADDR == pcsc_pkg::ADDR_PLL_PROGRAMMING;
    xe = syn2_q[pcsc_pkg::SYN_XTAL] & ~syn3_q[pcsc_pkg::SYN_XTAL];
    ve = syn2_q[pcsc_pkg::SYN_VCO] & ~syn3_q[pcsc_pkg::SYN_VCO];
    lock_s = auto_q & syn2_q[pcsc_pkg::SYN_LOCK];
    toggle = auto_q
      & (syn2_q[pcsc_pkg::SYN_LOCK] ^ syn3_q[pcsc_pkg::SYN_LOCK]);
    range_ok = range_q != 4'h0;
    n_eff = (mul_q == 4'h0) ? 4'h1 : mul_q;
    xld_limit = {n_eff, 2'b00};

    // Read images; masked fields read zero outside their mode
    ctrl_rd = {irq_en_q & auto_q, flag_q & auto_q, pll_on_q, bcs_q,
      pcsc_pkg::CTRL_LOW_ONES};
    bw_rd = {auto_q, lock_s, auto_q ? syn2_q[pcsc_pkg::SYN_TRACK] :
      acq_man_q, xld_q & bcs_q, 4'h0};

    // APB: data is prepared in setup, so access never waits
    pready_d = setup;
    pslverr_d = setup & ~(hit_ctrl | hit_bw | hit_prog);
    prdata_d = 32'h0000_0000;
    if (setup & ~PWRITE) begin
      if (hit_ctrl)
        prdata_d = {24'h00_0000, ctrl_rd};
      else if (hit_bw)
        prdata_d = {24'h00_0000, bw_rd};
      else if (hit_prog)
        prdata_d = {24'h00_0000, mul_q, range_q};
    end
    if (setup)
      rd_ctrl_d = ~PWRITE & hit_ctrl & flag_q;

    // Only a flag already seen by the read is cleared; a new toggle wins
    if (done & ~PWRITE & hit_ctrl & rd_ctrl_q)
      flag_d = 1'b0;
    if (toggle)
      flag_d = 1'b1;
    if (!auto_q)
      flag_d = 1'b0;

    if (wr & hit_ctrl) begin
      if (auto_q)
        irq_en_d = PWDATA[pcsc_pkg::BIT_LOCK_IRQ_ENABLE];
      // Checks use the old bits, so one write cannot do both steps
      if (PWDATA[pcsc_pkg::BIT_PLL_ON] | ~bcs_q)
        pll_on_d = PWDATA[pcsc_pkg::BIT_PLL_ON];
      if (~PWDATA[pcsc_pkg::BIT_BASE_SELECT] | (pll_on_q & range_ok))
        bcs_d = PWDATA[pcsc_pkg::BIT_BASE_SELECT];
    end
    if (wr & hit_bw) begin
      auto_d = PWDATA[pcsc_pkg::BIT_AUTO_MODE];
      if (!auto_q)
        acq_man_d = PWDATA[pcsc_pkg::BIT_TRACK];
    end
    // Programming is locked while the PLL is on
    if (wr & hit_prog & ~pll_on_q) begin
      mul_d = PWDATA[7:4];
      range_d = PWDATA[3:0];
    end
    if (!range_ok)
      bcs_d = 1'b0;
    if (STOP_IN)
      bcs_d = 1'b0;

    // Crystal loss: any rising crystal edge within 4*N rising VCO edges proves it alive
    if (xld_busy_q) begin
      if (xe) begin
        xld_d = 1'b0;
        xld_busy_d = 1'b0;
      end else if (ve) begin
        xld_cnt_d = xld_cnt_q + 6'h01;
        if (xld_cnt_d >= xld_limit)
          xld_busy_d = 1'b0;
      end
    end
    if (wr & hit_bw & PWDATA[pcsc_pkg::BIT_CRYSTAL_LOSS] & bcs_q) begin
      xld_d = 1'b1;
      xld_busy_d = 1'b1;
      xld_cnt_d = 6'h00;
    end
    if (!bcs_q) begin
      xld_d = 1'b0;
      xld_busy_d = 1'b0;
    end

    // Base clock: hold during switchover, then halve selected source
    if (STOP_IN) begin
      base_d = 1'b0;
      sel_d = 1'b0;
      cnt_x_d = 2'h0;
      cnt_v_d = 2'h0;
    end else if (sel_q != bcs_q) begin
      if (xe && cnt_x_q != pcsc_pkg::SWITCH_EDGES)
        cnt_x_d = cnt_x_q + 2'h1;
      if (ve && cnt_v_q != pcsc_pkg::SWITCH_EDGES)
        cnt_v_d = cnt_v_q + 2'h1;
      if (cnt_x_q == pcsc_pkg::SWITCH_EDGES
          && cnt_v_q == pcsc_pkg::SWITCH_EDGES) begin
        sel_d = bcs_q;
        cnt_x_d = 2'h0;
        cnt_v_d = 2'h0;
      end
    end else begin
      // A select that flips back before finishing leaves no partial count
      cnt_x_d = 2'h0;
      cnt_v_d = 2'h0;
      if (sel_q ? ve : xe)
        base_d = ~base_q;
    end

    xclk_d = syn2_q[pcsc_pkg::SYN_XTAL] & OSC_ENABLE_IN & ~STOP_IN;
    irq_d = ~STOP_IN & auto_d & flag_d & irq_en_d;
    pll_en_d = pll_on_d & OSC_ENABLE_IN & range_ok
      & ~STOP_IN;
    track_d = auto_d ? syn2_q[pcsc_pkg::SYN_TRACK] : acq_man_d;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      syn1_q <= 4'h0;
      syn2_q <= 4'h0;
      syn3_q <= 4'h0;
      irq_en_q <= 1'b0;
      flag_q <= 1'b0;
      pll_on_q <= 1'b1;
      bcs_q <= 1'b0;
      auto_q <= 1'b0;
      acq_man_q <= 1'b0;
      xld_q <= 1'b0;
      xld_busy_q <= 1'b0;
      xld_cnt_q <= 6'h00;
      mul_q <= pcsc_pkg::MULTIPLIER_RESET;
      range_q <= pcsc_pkg::RANGE_RESET;
      sel_q <= 1'b0;
      cnt_x_q <= 2'h0;
      cnt_v_q <= 2'h0;
      base_q <= 1'b0;
      xclk_q <= 1'b0;
      irq_q <= 1'b0;
      pll_en_q <= 1'b0;
      track_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rd_ctrl_q <= 1'b0;
    end else begin
      syn1_q <= syn1_d;
      syn2_q <= syn2_d;
      syn3_q <= syn3_d;
      irq_en_q <= irq_en_d;
      flag_q <= flag_d;
      pll_on_q <= pll_on_d;
      bcs_q <= bcs_d;
      auto_q <= auto_d;
      acq_man_q <= acq_man_d;
      xld_q <= xld_d;
      xld_busy_q <= xld_busy_d;
      xld_cnt_q <= xld_cnt_d;
      mul_q <= mul_d;
      range_q <= range_d;
      sel_q <= sel_d;
      cnt_x_q <= cnt_x_d;
      cnt_v_q <= cnt_v_d;
      base_q <= base_d;
      xclk_q <= xclk_d;
      irq_q <= irq_d;
      pll_en_q <= pll_en_d;
      track_q <= track_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      rd_ctrl_q <= rd_ctrl_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign CRYSTAL_CLOCK = xclk_q;
  assign BASE_CLOCK = base_q;
  assign CLOCKGEN_IRQ = irq_q;
  assign PLL_ENABLE = pll_en_q;
  assign FILTER_TRACK = track_q;

endmodule

// >>> pcsc_top_monitor.sv
// Purpose: port checks for the clock select control block
// Assumes: one SYS_CLK domain, zero wait state bus
// Notes: sources must run at SYS_CLK / 4 or slower
`timescale 1ns/10ps
module pcsc_mon (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic OSC_ENABLE_IN,
  input wire logic STOP_IN,
  input wire logic CRYSTAL_CLOCK,
  input wire logic BASE_CLOCK,
  input wire logic CLOCKGEN_IRQ,
  input wire logic PLL_ENABLE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence read_s(logic [11:0] a);
    setup_s ##0 (!PWRITE && PADDR == a);
  endsequence
  ready_next_a: assert property (setup_s |=> PREADY)
    else $error("no ready after setup");
  ready_once_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  data_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  ctl_ones_a: assert property (
    read_s(pcsc_pkg::ADDR_PLL_CONTROL) |=> PRDATA[3:0] == 4'hF)
    else $error("low control bits not ones");
  bad_addr_a: assert property (
    setup_s ##0 PADDR > 12'h008 |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  stop_low_a: assert property (
    STOP_IN |=> !CRYSTAL_CLOCK && !CLOCKGEN_IRQ && !PLL_ENABLE)
    else $error("outputs active in stop");
  osc_off_a: assert property (
    !OSC_ENABLE_IN |=> !PLL_ENABLE && !CRYSTAL_CLOCK)
    else $error("generator active while disabled");
  base_half_a: assert property (
    $changed(BASE_CLOCK) && !STOP_IN |=> $stable(BASE_CLOCK) [*3])
    else $error("base clock edge too soon");
endmodule

// >>> pll_clock_select_control_test.sv
// Purpose: self-checking bench for the clock select control block
// Assumes: zero wait state bus, sources at SYS_CLK / 8 or slower
// Notes: reads queue their expected byte, a watcher compares
`timescale 1ns/10ps
module pll_clock_select_control_test;
  localparam logic [11:0] CTL = pcsc_pkg::ADDR_PLL_CONTROL;
  localparam logic [11:0] BW = pcsc_pkg::ADDR_PLL_BANDWIDTH_CONTROL;
  localparam logic [11:0] PRG = pcsc_pkg::ADDR_PLL_PROGRAMMING;
  localparam int XH = 30;
  localparam int VH = 20;
  logic SYS_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR, ra;
  logic [31:0] PWDATA, PRDATA;
  logic XTAL_CLOCK_IN, VCO_CLOCK_IN, LOCK_IN, TRACK_IN, OSC_ENABLE_IN;
  logic STOP_IN, CRYSTAL_CLOCK, BASE_CLOCK, CLOCKGEN_IRQ, PLL_ENABLE;
  logic FILTER_TRACK, x_run, v_run, lk, tr;
  logic [8:0] exp_q[$], n;
  int failures, n_compared, cyc, seed;
  pcsc_top dut_u (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .XTAL_CLOCK_IN, .VCO_CLOCK_IN,
    .LOCK_IN, .TRACK_IN, .OSC_ENABLE_IN, .STOP_IN, .CRYSTAL_CLOCK,
    .BASE_CLOCK, .CLOCKGEN_IRQ, .PLL_ENABLE, .FILTER_TRACK);
  pcsc_src_model #(.XTAL_HALF(XH), .VCO_HALF(VH)) src_u (.xtal_run(x_run),
    .vco_run(v_run), .lock_set(lk), .track_set(tr),
    .xtal_clk(XTAL_CLOCK_IN), .vco_clk(VCO_CLOCK_IN), .lock_lvl(LOCK_IN),
    .track_lvl(TRACK_IN));
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] want,
      input string what);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Whole request held until the edge that sees PREADY
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [8:0] d);
    if (!w) exp_q.push_back(d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d[7:0]};
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic lvl(input logic v);
    wait (BASE_CLOCK !== v);
    wait (BASE_CLOCK === v);
    n = 9'h000;
    @(negedge SYS_CLK);
    while (BASE_CLOCK === v) begin
      n++;
      @(negedge SYS_CLK);
    end
    @(posedge SYS_CLK);
  endtask
  task automatic loss(input logic [8:0] d);
    xfer(1'b1, BW, 9'h010);
    repeat (4 * pcsc_pkg::MULTIPLIER_RESET * 2 * VH / 5 + 20)
      @(posedge SYS_CLK);
    xfer(1'b0, BW, d);
  endtask
  always @(posedge SYS_CLK) begin
    if (PREADY === 1'b1 && PSEL && PENABLE && !PWRITE)
      chk({PSLVERR, PRDATA[7:0]}, exp_q.pop_front(), "read");
  end
  // Run is under 1000 cycles, so this only cuts a hang
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    seed = 32'h8008f063;
    {RST, PSEL, PENABLE, PWRITE, STOP_IN} = 5'h10;
    {x_run, v_run, lk, tr, OSC_ENABLE_IN} = 5'h19;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    ra = (12'($random(seed)) & 12'hFFC) | 12'h010;
    xfer(1'b0, CTL, 9'h02F);
    xfer(1'b0, BW, 9'h000);
    xfer(1'b0, PRG, {1'b0, pcsc_pkg::MULTIPLIER_RESET,
      pcsc_pkg::RANGE_RESET});
    xfer(1'b1, ra, 9'h0FF);
    xfer(1'b0, ra, 9'h100);
    chk(9'(PLL_ENABLE), 9'h001, "pll on");
    xfer(1'b1, CTL, 9'h000);
    xfer(1'b1, CTL, 9'h030);
    xfer(1'b0, CTL, 9'h02F);
    xfer(1'b1, CTL, 9'h030);
    xfer(1'b0, CTL, 9'h03F);
    xfer(1'b1, CTL, 9'h000);
    xfer(1'b0, CTL, 9'h02F);
    $display("interlock test done");
    lvl(1'b1);
    chk(n, 9'(2 * XH / 5), "xtal high");
    lvl(1'b0);
    chk(n, 9'(2 * XH / 5), "xtal low");
    xfer(1'b1, CTL, 9'h030);
    repeat (40) @(posedge SYS_CLK);
    lvl(1'b1);
    chk(n, 9'(2 * VH / 5), "vco high");
    $display("base clock test done");
    loss(9'h000);
    x_run <= 1'b0;
    loss(9'h010);
    {x_run, v_run, OSC_ENABLE_IN} <= 3'h0;
    repeat (20) @(posedge SYS_CLK);
    STOP_IN <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    chk(9'(BASE_CLOCK), 9'h000, "stop base");
    {x_run, v_run, OSC_ENABLE_IN, STOP_IN} <= 4'hE;
    @(posedge SYS_CLK);
    xfer(1'b0, CTL, 9'h02F);
    xfer(1'b0, BW, 9'h000);
    $display("loss and stop test done");
    xfer(1'b1, CTL, 9'h000);
    xfer(1'b1, PRG, 9'h060);
    xfer(1'b0, PRG, 9'h060);
    xfer(1'b1, CTL, 9'h020);
    xfer(1'b1, CTL, 9'h030);
    xfer(1'b0, CTL, 9'h02F);
    chk(9'(PLL_ENABLE), 9'h000, "range zero");
    xfer(1'b1, CTL, 9'h000);
    xfer(1'b1, PRG, 9'h066);
    xfer(1'b1, CTL, 9'h020);
    $display("range test done");
    xfer(1'b1, BW, 9'h020);
    chk(9'(FILTER_TRACK), 9'h001, "manual track");
    lk <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    xfer(1'b1, BW, 9'h0A0);
    xfer(1'b0, BW, 9'h0C0);
    chk(9'(FILTER_TRACK), 9'h000, "auto track");
    xfer(1'b1, CTL, 9'h0A0);
    lk <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    chk(9'(CLOCKGEN_IRQ), 9'h001, "irq up");
    xfer(1'b0, CTL, 9'h0EF);
    xfer(1'b0, CTL, 9'h0AF);
    chk(9'(CLOCKGEN_IRQ), 9'h000, "irq down");
    xfer(1'b1, CTL, 9'h020);
    xfer(1'b1, BW, 9'h000);
    xfer(1'b0, BW, 9'h020);
    xfer(1'b1, CTL, 9'h0A0);
    lk <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    xfer(1'b0, CTL, 9'h02F);
    xfer(1'b1, BW, 9'h080);
    xfer(1'b0, CTL, 9'h02F);
    $display("auto mode test done");
    end_sim();
  end
endmodule
bind pcsc_top pcsc_mon mon_u (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PRDATA, .PREADY, .PSLVERR, .OSC_ENABLE_IN, .STOP_IN,
  .CRYSTAL_CLOCK, .BASE_CLOCK, .CLOCKGEN_IRQ, .PLL_ENABLE);
